// ---- csi_hs_timing_regs.sv ----
// Purpose: HS timing override register bank for the CSI-2 output port.
// Assumes: Register port strobes are one cycle, never both at once.
// Notes: Read data stand only in the cycle after the read strobe.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "csi_timing_defines.svh"
module csi_hs_timing_regs
#(
  parameter int VALUE_W = `CSI_VALUE_W
)
(
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port
  input wire csi_timing_pkg::bus_req_t bus_in,
  output logic [7:0] rdata_out,
  // Lane rate in use
  input wire csi_timing_pkg::csi_rate_t rate_sel_in,
  // Timing to the output port
  output csi_timing_pkg::timing_set_t timing_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (VALUE_W != 7)
  begin : g_width_check
    $error("Value field must be seven bits below the override bit.");
  end

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  logic [4:0][6:0] auto_value;

  timing_auto_derive u_derive
  (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .rate_sel_in(rate_sel_in),
    .auto_value_out(auto_value)
  );

  // ----------------------------------------------------------------
  // Timing registers
  // ----------------------------------------------------------------
  logic [7:0] rb_prepare;
  logic [7:0] rb_zero;
  logic [7:0] rb_trail;
  logic [7:0] rb_exit;
  logic [7:0] rb_lp;

  // HS-prepare.
  timing_field_reg #(.ADDR(`CSI_HS_PREPARE_OFFSET), .RESET_VALUE(`CSI_HS_PREPARE_RESET)) u_prepare
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .bus_in(bus_in),
    .auto_value_in(auto_value[0]),
    .override_en_out(timing_out.hs_prepare_override_en),
    .value_out(timing_out.hs_prepare_value),
    .readback_out(rb_prepare)
  );

  // HS-zero.
  timing_field_reg #(.ADDR(`CSI_HS_ZERO_OFFSET), .RESET_VALUE(`CSI_HS_ZERO_RESET)) u_zero
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .bus_in(bus_in),
    .auto_value_in(auto_value[1]),
    .override_en_out(timing_out.hs_zero_override_en),
    .value_out(timing_out.hs_zero_value),
    .readback_out(rb_zero)
  );

  // HS-trail.
  timing_field_reg #(.ADDR(`CSI_HS_TRAIL_OFFSET), .RESET_VALUE(`CSI_HS_TRAIL_RESET)) u_trail
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .bus_in(bus_in),
    .auto_value_in(auto_value[2]),
    .override_en_out(timing_out.hs_trail_override_en),
    .value_out(timing_out.hs_trail_value),
    .readback_out(rb_trail)
  );

  // HS-exit.
  timing_field_reg #(.ADDR(`CSI_HS_EXIT_OFFSET), .RESET_VALUE(`CSI_HS_EXIT_RESET)) u_exit
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .bus_in(bus_in),
    .auto_value_in(auto_value[3]),
    .override_en_out(timing_out.hs_exit_override_en),
    .value_out(timing_out.hs_exit_value),
    .readback_out(rb_exit)
  );

  // LPX period.
  timing_field_reg #(.ADDR(`CSI_LP_PERIOD_OFFSET), .RESET_VALUE(`CSI_LP_PERIOD_RESET)) u_lp
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .bus_in(bus_in),
    .auto_value_in(auto_value[4]),
    .override_en_out(timing_out.lp_period_override_en),
    .value_out(timing_out.lp_period_value),
    .readback_out(rb_lp)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire logic sel_prepare = bus_in.addr == `CSI_HS_PREPARE_OFFSET;
  wire logic sel_zero = bus_in.addr == `CSI_HS_ZERO_OFFSET;
  wire logic sel_trail = bus_in.addr == `CSI_HS_TRAIL_OFFSET;
  wire logic sel_exit = bus_in.addr == `CSI_HS_EXIT_OFFSET;
  wire logic sel_lp = bus_in.addr == `CSI_LP_PERIOD_OFFSET;

  // Unmapped addresses read as zero.
  wire logic [7:0] read_mux = sel_prepare ? rb_prepare :
                              sel_zero ? rb_zero :
                              sel_trail ? rb_trail :
                              sel_exit ? rb_exit :
                              sel_lp ? rb_lp : 8'h00;

  logic [7:0] next_rdata;
  assign next_rdata = bus_in.rd ? read_mux : 8'h00;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (ce_in)
      rdata_out <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  // Set from reset until the first enabled edge.
  logic fresh;
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      fresh <= 1'b1;
    else if (ce_in)
      fresh <= 1'b0;
  end

  sequence write_override(logic [7:0] addr);
    ce_in && bus_in.wr && bus_in.addr == addr && bus_in.wdata[7];
  endsequence

  sequence read_back(logic [7:0] addr);
    ce_in && bus_in.rd && bus_in.addr == addr;
  endsequence

  prepare_override_a: assert property (
    write_override(`CSI_HS_PREPARE_OFFSET) |=> timing_out.hs_prepare_override_en
      && timing_out.hs_prepare_value == $past(bus_in.wdata[6:0]))
    else $error("HS-prepare override did not take the written value.");

  zero_select_a: assert property (
    !timing_out.hs_zero_override_en |-> timing_out.hs_zero_value == auto_value[1])
    else $error("HS-zero does not follow the derived value.");

  trail_select_a: assert property (
    write_override(`CSI_HS_TRAIL_OFFSET) ##1 (!(ce_in && bus_in.wr))[*2]
      |-> timing_out.hs_trail_value == $past(bus_in.wdata[6:0], 2))
    else $error("HS-trail programmed value was not held.");

  exit_select_a: assert property (
    !timing_out.hs_exit_override_en |-> timing_out.hs_exit_value == auto_value[3])
    else $error("HS-exit does not follow the derived value.");

  lp_select_a: assert property (
    write_override(`CSI_LP_PERIOD_OFFSET) |=> timing_out.lp_period_override_en
      && timing_out.lp_period_value == $past(bus_in.wdata[6:0]))
    else $error("LPX override did not take the written value.");

  readonly_field_a: assert property (
    ce_in && bus_in.wr && bus_in.addr == `CSI_HS_PREPARE_OFFSET && !bus_in.wdata[7]
      |=> !timing_out.hs_prepare_override_en && timing_out.hs_prepare_value == auto_value[0])
    else $error("Write with override clear changed the value field.");

  readwrite_field_a: assert property (
    write_override(`CSI_HS_ZERO_OFFSET) ##1 !(ce_in && bus_in.wr)
      ##1 read_back(`CSI_HS_ZERO_OFFSET) |=> rdata_out == {1'b1, $past(bus_in.wdata[6:0], 3)})
    else $error("Programmed HS-zero did not read back.");

  rate_derive_a: assert property (
    ce_in && rate_sel_in == csi_timing_pkg::RATE_800 |=> auto_value[0] == `CSI_HS_PREPARE_RESET
      && auto_value[2] == `CSI_HS_TRAIL_RESET && auto_value[4] == `CSI_LP_PERIOD_RESET)
    else $error("Derived values do not match the 800 Mbps figures.");

  rate_double_a: assert property (
    ce_in && rate_sel_in == csi_timing_pkg::RATE_1600 |=> auto_value[1] == 7'h18)
    else $error("Derived HS-zero not doubled at 1600 Mbps.");

  reset_first_a: assert property (
    fresh |-> rb_prepare == 8'h06 && rb_zero == 8'h0c && rb_trail == 8'h08)
    else $error("Prepare, zero or trail register wrong after reset.");

  reset_second_a: assert property (
    fresh |-> rb_exit == 8'h0b && rb_lp == 8'h06)
    else $error("Exit or LPX register wrong after reset.");

  read_whole_a: assert property (
    read_back(`CSI_HS_EXIT_OFFSET) |=> rdata_out == $past(rb_exit))
    else $error("Read did not return override and value together.");

  read_only_then_a: assert property (
    ce_in && !bus_in.rd |=> rdata_out == 8'h00)
    else $error("Read data stood outside the cycle after a read.");

endmodule
`default_nettype wire

// ---- csi_hs_timing_regs_tb.sv ----
// Purpose: Self-checking bench for the HS timing override register bank.
// Assumes: Strobes last one cycle; read data stand only in the cycle after the read.
// Notes: Random traffic from a fixed seed, mixed with hand-written corner cases.
`timescale 1ns/10ps
`default_nettype none
`include "csi_timing_defines.svh"
module csi_hs_timing_regs_tb;
  // ----------------------------------------------------------------
  // Stimulus, model state and design
  // ----------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b0;
  csi_timing_pkg::bus_req_t bus_in = '0;
  csi_timing_pkg::csi_rate_t rate_sel_in = csi_timing_pkg::RATE_800;
  logic [7:0] rdata_out;
  csi_timing_pkg::timing_set_t timing_out;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'h0d01a736;
  int r;
  logic ov [5];
  logic [6:0] man [5];
  csi_timing_pkg::csi_rate_t cur_rate = csi_timing_pkg::RATE_800;
  csi_timing_pkg::csi_rate_t rates [6] = '{csi_timing_pkg::RATE_400, csi_timing_pkg::RATE_800,
    csi_timing_pkg::RATE_1200, csi_timing_pkg::RATE_1500, csi_timing_pkg::RATE_1600,
    csi_timing_pkg::csi_rate_t'(3'h7)};

  always #25 mclk_in = ~mclk_in;

  csi_hs_timing_regs DUT (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .bus_in(bus_in),
    .rdata_out(rdata_out),
    .rate_sel_in(rate_sel_in),
    .timing_out(timing_out)
  );

  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  function automatic logic [6:0] derived(int idx, csi_timing_pkg::csi_rate_t rt);
    logic [6:0] base [5];
    int f;
    int v;
    base = '{`CSI_HS_PREPARE_RESET, `CSI_HS_ZERO_RESET, `CSI_HS_TRAIL_RESET,
      `CSI_HS_EXIT_RESET, `CSI_LP_PERIOD_RESET};
    case (rt)
      csi_timing_pkg::RATE_400: f = 4;
      csi_timing_pkg::RATE_1200: f = 12;
      csi_timing_pkg::RATE_1500: f = 15;
      csi_timing_pkg::RATE_1600: f = 16;
      default: f = 8;
    endcase
    v = (base[idx] * f + 7) / 8;
    return (v > 127) ? 7'h7f : v[6:0];
  endfunction

  function automatic logic [7:0] exp_reg(int idx);
    return ov[idx] ? {1'b1, man[idx]} : {1'b0, derived(idx, cur_rate)};
  endfunction

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic check(input logic [39:0] got, input logic [39:0] expv, input string what);
    checks_done++;
    if (got !== expv)
    begin
      errors++;
      $display("[ERR] t=%0t %s got %h expected %h", $time, what, got, expv);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_in);
    bus_in.wr <= 1'b0;
    if (ce_in && a >= 8'h44 && a <= 8'h48)
    begin
      ov[a - 8'h44] = d[7];
      if (d[7])
        man[a - 8'h44] = d[6:0];
    end
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic [7:0] expv;
    expv = (a >= 8'h44 && a <= 8'h48) ? exp_reg(a - 8'h44) : 8'h00;
    @(posedge mclk_in);
    bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'($random(seed))};
    @(posedge mclk_in);
    bus_in.rd <= 1'b0;
    #1;
    check({32'h0, rdata_out}, {32'h0, expv}, "read");
  endtask

  task automatic chk_timing;
    #1;
    check(timing_out, {exp_reg(0), exp_reg(1), exp_reg(2), exp_reg(3), exp_reg(4)}, "timing");
  endtask

  task automatic read_all;
    for (int i = 0; i < 5; i++)
      rd_reg(8'h44 + 8'(i));
    chk_timing();
  endtask

  task automatic set_rate(input csi_timing_pkg::csi_rate_t rt);
    @(posedge mclk_in);
    rate_sel_in <= rt;
    cur_rate = rt;
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #(50 * 20000);
    errors++;
    $display("[ERR] t=%0t watchdog expired got %h expected %h", $time, 1'b1, 1'b0);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      ov[i] = 1'b0;
      man[i] = 7'h00;
    end
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    ce_in <= 1'b1;
    @(posedge mclk_in);
    chk_timing();
    read_all();
    $display("test reset values done");
    for (int i = 0; i < 5; i++)
      wr_reg(8'h44 + 8'(i), {1'b0, 7'($random(seed))});
    read_all();
    $display("test write with override clear done");
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(8'h44 + 8'(i), (i == 1) ? 8'h80 : ((i == 3) ? 8'hff : {1'b1, 7'($random(seed))}));
      rd_reg(8'h44 + 8'(i));
      chk_timing();
    end
    wr_reg(8'h44, 8'h15);
    wr_reg(8'h46, 8'h00);
    read_all();
    $display("test override set and clear done");
    for (int k = 0; k < 6; k++)
    begin
      set_rate(rates[k]);
      read_all();
    end
    $display("test rate changes done");
    @(posedge mclk_in);
    ce_in <= 1'b0;
    wr_reg(8'h45, 8'hc4);
    ce_in <= 1'b1;
    read_all();
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(8'h43 + 8'(i * 6), 8'hff);
      rd_reg(8'h43 + 8'(i * 6));
    end
    rd_reg(8'h47);
    @(posedge mclk_in);
    #1;
    check({32'h0, rdata_out}, 40'h0, "read data after its cycle");
    read_all();
    $display("test unmapped and enable done");
    for (int n = 0; n < 300; n++)
    begin
      r = $random(seed);
      if (r[1:0] == 2'h3 && r[4])
        set_rate(rates[$unsigned(r[14:12]) % 6]);
      else if (r[0])
        wr_reg(8'h43 + 8'($unsigned(r[10:8]) % 7), r[23:16]);
      else
        rd_reg(8'h43 + 8'($unsigned(r[10:8]) % 7));
      if (n % 25 == 0)
        chk_timing();
    end
    read_all();
    $display("test random traffic done");
    wr_reg(8'h46, 8'hc2);
    set_rate(csi_timing_pkg::RATE_800);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++)
      ov[i] = 1'b0;
    #1;
    check(timing_out, {8'h06, 8'h0c, 8'h08, 8'h0b, 8'h06}, "timing after reset");
    check({32'h0, rdata_out}, 40'h0, "read data after reset");
    read_all();
    $display("test reset in mid-run done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- csi_timing_defines.svh ----
// Purpose: Offsets, field positions, reset values and rate factors of the HS timing bank.
// Assumes: Byte-wide registers reached over a plain strobe port.
// Notes: Definitions only.
`ifndef CSI_TIMING_DEFINES_SVH
`define CSI_TIMING_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSI_HS_PREPARE_OFFSET 8'h44
`define CSI_HS_ZERO_OFFSET 8'h45
`define CSI_HS_TRAIL_OFFSET 8'h46
`define CSI_HS_EXIT_OFFSET 8'h47
`define CSI_LP_PERIOD_OFFSET 8'h48

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define CSI_OVERRIDE_BIT 7
`define CSI_VALUE_W 7

// ----------------------------------------------------------------
// Reset values of the value fields, derived for 800 Mbps
// ----------------------------------------------------------------
`define CSI_HS_PREPARE_RESET 7'h06
`define CSI_HS_ZERO_RESET 7'h0c
`define CSI_HS_TRAIL_RESET 7'h08
`define CSI_HS_EXIT_RESET 7'h0b
`define CSI_LP_PERIOD_RESET 7'h06

// ----------------------------------------------------------------
// Rate factors in eighths of the 800 Mbps count
// ----------------------------------------------------------------
`define CSI_FACTOR_400 5'h04
`define CSI_FACTOR_800 5'h08
`define CSI_FACTOR_1200 5'h0c
`define CSI_FACTOR_1500 5'h0f
`define CSI_FACTOR_1600 5'h10

`endif

// ---- csi_timing_pkg.sv ----
// Purpose: Types shared by the HS timing register bank.
// Assumes: Nothing beyond the defines header.
// Notes: Holds types only.
package csi_timing_pkg;

  // ----------------------------------------------------------------
  // Lane rate selection
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    RATE_400 = 3'h0,
    RATE_800 = 3'h1,
    RATE_1200 = 3'h3,
    RATE_1500 = 3'h2,
    RATE_1600 = 3'h6
  } csi_rate_t;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // ----------------------------------------------------------------
  // Timing handed to the output port
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic hs_prepare_override_en;
    logic [6:0] hs_prepare_value;
    logic hs_zero_override_en;
    logic [6:0] hs_zero_value;
    logic hs_trail_override_en;
    logic [6:0] hs_trail_value;
    logic hs_exit_override_en;
    logic [6:0] hs_exit_value;
    logic lp_period_override_en;
    logic [6:0] lp_period_value;
  } timing_set_t;

endpackage

// ---- timing_auto_derive.sv ----
// Purpose: Derives the five HS timing counts for the selected lane rate.
// Assumes: Counts scale with the bit rate from their 800 Mbps figures.
// Notes: Rounds up, saturates at 7 bits; output is registered.
`timescale 1ns/10ps
`default_nettype none
`include "csi_timing_defines.svh"
module timing_auto_derive
#(
  parameter logic [4:0][6:0] BASE_VALUES = {`CSI_LP_PERIOD_RESET, `CSI_HS_EXIT_RESET,
    `CSI_HS_TRAIL_RESET, `CSI_HS_ZERO_RESET, `CSI_HS_PREPARE_RESET}
)
(
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Rate selection
  input wire csi_timing_pkg::csi_rate_t rate_sel_in,
  // Derived counts, index 0 prepare to 4 LPX
  output logic [4:0][6:0] auto_value_out
);

  function automatic logic [6:0] scale(input logic [6:0] base, input logic [4:0] factor);
    logic [12:0] product;
    logic [9:0] quotient;
    product = ({6'h00, base} * {8'h00, factor}) + 13'h0007;
    quotient = product[12:3];
    scale = (quotient > 10'h07f) ? 7'h7f : quotient[6:0];
  endfunction

  logic [4:0] factor;
  logic [4:0][6:0] next_auto_value;

  always_comb
  begin
    unique case (rate_sel_in)
      csi_timing_pkg::RATE_400: factor = `CSI_FACTOR_400;
      csi_timing_pkg::RATE_800: factor = `CSI_FACTOR_800;
      csi_timing_pkg::RATE_1200: factor = `CSI_FACTOR_1200;
      csi_timing_pkg::RATE_1500: factor = `CSI_FACTOR_1500;
      csi_timing_pkg::RATE_1600: factor = `CSI_FACTOR_1600;
      default: factor = `CSI_FACTOR_800;
    endcase
    for (int i = 0; i < 5; i++)
      next_auto_value[i] = scale(BASE_VALUES[i], factor);
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      auto_value_out <= BASE_VALUES;
    else if (ce_in)
      auto_value_out <= next_auto_value;
  end

endmodule
`default_nettype wire

// ---- timing_field_reg.sv ----
// Purpose: One override-capable timing register.
// Assumes: Inputs synchronous to mclk_in.
// Notes: A write with bit 7 set loads the value field; the new value shows from the next cycle.
`timescale 1ns/10ps
`default_nettype none
`include "csi_timing_defines.svh"
module timing_field_reg
#(
  parameter logic [7:0] ADDR = `CSI_HS_PREPARE_OFFSET,
  parameter logic [6:0] RESET_VALUE = `CSI_HS_PREPARE_RESET
)
(
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port and derived value
  input wire csi_timing_pkg::bus_req_t bus_in,
  input wire logic [6:0] auto_value_in,
  // Effective timing and readback
  output logic override_en_out,
  output logic [6:0] value_out,
  output logic [7:0] readback_out
);

  logic override_en;
  logic [6:0] manual_value;
  wire logic hit = bus_in.wr && (bus_in.addr == ADDR);
  wire logic set_override = bus_in.wdata[`CSI_OVERRIDE_BIT];

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      override_en <= 1'b0;
      manual_value <= RESET_VALUE;
    end
    else if (ce_in && hit)
    begin
      override_en <= set_override;
      // Value bits only take a write while override is being set.
      if (set_override)
        manual_value <= bus_in.wdata[6:0];
    end
  end

  // Derived value is shown and used until override is set.
  assign override_en_out = override_en;
  assign value_out = override_en ? manual_value : auto_value_in;
  assign readback_out = {override_en, value_out};

endmodule
`default_nettype wire
